/* hw/asalu_pkg.sv */
package asalu_pkg;

  // Data and pointer widths
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned PTR_W     = 16;
  localparam int unsigned PTR_IMM_W = 6;
  localparam int unsigned PTR_EXT_W = PTR_W - PTR_IMM_W;
  localparam int unsigned INSTR_W   = 14;
  localparam int unsigned NUM_PTR   = 2;

  // Add-to-pointer opcode: bits 13:7 of 11 0001 0nkk kkkk
  localparam logic [6:0]  PTR_OPC     = 7'h62;
  localparam int unsigned OPC_HI      = 13;
  localparam int unsigned OPC_LO      = 7;
  localparam int unsigned PTR_SEL_BIT = 6;
  localparam int unsigned DEST_BIT    = 7;

  // Bit positions
  localparam int unsigned MSB      = DATA_W - 1;
  localparam int unsigned PTR_MSB  = PTR_W - 1;
  localparam int unsigned NIB_W    = 4;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_B   = 8'h00;

  // Register-side operations, chosen by the core decoder
  typedef enum logic [2:0] {
    OP_NONE                    = 3'h0,
    OP_ADD_IMM_TO_ACC          = 3'h1,
    OP_ADD_ACC_TO_REG          = 3'h2,
    OP_ADD_ACC_REG_WITH_CARRY  = 3'h3,
    OP_AND_ACC_WITH_REG        = 3'h4,
    OP_AND_ACC_WITH_IMM        = 3'h5,
    OP_ARITH_SHIFT_RIGHT       = 3'h6
  } asalu_op_e;

  // Execution state
  typedef enum logic {
    ST_IDLE    = 1'b0,
    ST_STRETCH = 1'b1
  } asalu_state_e;

  // One instruction with its operand
  typedef struct packed {
    asalu_op_e         op;
    logic              is_ptr;
    logic [INSTR_W-1:0] instr;
    logic [DATA_W-1:0] reg_data;
  } asalu_req_s;

  // Status flags
  typedef struct packed {
    logic carry;
    logic half_carry;
    logic zero;
  } asalu_flags_s;

endpackage : asalu_pkg

/* hw/asalu_core.sv */
// Functional notes
// RQ1: Pointer add sign-extends 6-bit literal, flags kept
// RQ2: Pointer sum wraps modulo 65536
// RQ3: Literal add sets carry, half carry, zero
// RQ4: Accumulator plus register sets carry, half carry, zero
// RQ5: Destination bit picks accumulator or file register
// RQ6: AND with register changes only zero flag
// RQ7: Add with carry uses three-input sum
// RQ8: Shift right keeps MSb, bit 0 to carry
// RQ9: AND with literal changes only zero flag
// RQ10: Indirect port with pointer MSb adds a cycle
// RQ11: Pointer add decoded from pattern, one cycle
// RQ12: Zero on zero result; carries from bits 7, 3
module asalu_core #(
  parameter logic [6:0] INDIRECT_ADDR0 = 7'h00,  // Indirect access port 0 address
  parameter logic [6:0] INDIRECT_ADDR1 = 7'h01   // Indirect access port 1 address
) (
  input  wire logic                                i_clk,
  input  wire logic                                i_rst,
  input  wire logic                                i_valid,
  input  wire logic [asalu_pkg::INSTR_W-1:0]       i_instr,
  input  wire asalu_pkg::asalu_op_e                i_op,
  input  wire logic [asalu_pkg::DATA_W-1:0]        i_reg_data,
  output logic                                     o_ready,
  output logic                                     o_done,
  output logic [asalu_pkg::DATA_W-1:0]             o_acc,
  output logic                                     o_carry,
  output logic                                     o_half_carry,
  output logic                                     o_zero,
  output logic [asalu_pkg::PTR_W-1:0]              o_ptr0,
  output logic [asalu_pkg::PTR_W-1:0]              o_ptr1,
  output logic                                     o_mem_we,
  output logic [asalu_pkg::ADDR_W-1:0]             o_mem_addr,
  output logic [asalu_pkg::DATA_W-1:0]             o_mem_wdata
);

  // Architectural state
  asalu_pkg::asalu_state_e              state;       // Execution state
  asalu_pkg::asalu_state_e              next_state;  // Next execution state
  asalu_pkg::asalu_req_s                held;        // Request held over a stretch
  asalu_pkg::asalu_flags_s              flags;       // Status flags
  asalu_pkg::asalu_flags_s              next_flags;  // Flags after commit
  logic [asalu_pkg::DATA_W-1:0]         acc;         // Accumulator
  logic [asalu_pkg::DATA_W-1:0]         next_acc;    // Accumulator after commit
  logic [asalu_pkg::PTR_W-1:0]          ptr [asalu_pkg::NUM_PTR];  // Pointer pairs
  logic                                 done;        // Completion pulse

  // Request decode
  asalu_pkg::asalu_req_s                req_in;      // Request from the ports
  asalu_pkg::asalu_req_s                cur;         // Request being executed
  wire logic                            is_ptr_in;   // Pointer add pattern seen
  wire logic                            idle;        // Ready for a new request
  wire logic                            take;        // Request accepted now
  wire logic                            reg_op;      // Operand is a file register
  wire logic                            ind_hit;     // Indirect port, pointer MSb set
  wire logic                            need_stretch;// Accept into the extra cycle
  wire logic                            commit;      // Results land this edge
  wire logic                            ptr_sel;     // Selected pointer pair
  wire logic [asalu_pkg::PTR_IMM_W-1:0] ptr_imm;     // Signed pointer literal
  wire logic [asalu_pkg::PTR_W-1:0]     ptr_ext;     // Sign-extended literal
  wire logic [asalu_pkg::PTR_W-1:0]     ptr_sum;     // Wrapped pointer sum
  wire logic [asalu_pkg::DATA_W-1:0]    imm;         // Byte literal
  wire logic [asalu_pkg::ADDR_W-1:0]    addr;        // File register address
  wire logic                            dest;        // Destination bit

  // Datapath
  wire logic [asalu_pkg::DATA_W-1:0]    add_b;       // Second adder operand
  wire logic                            cin;         // Adder carry in
  wire logic [asalu_pkg::NIB_W:0]       lo_sum;      // Low nibble sum
  wire logic [asalu_pkg::DATA_W:0]      full_sum;    // Full byte sum
  wire logic [asalu_pkg::DATA_W-1:0]    and_res;     // AND result
  wire logic [asalu_pkg::DATA_W-1:0]    asr_res;     // Shift result
  wire logic                            is_add;      // Any add operation
  wire logic                            is_and;      // Any AND operation
  wire logic                            is_asr;      // Shift operation
  wire logic [asalu_pkg::DATA_W-1:0]    result;      // Selected result
  wire logic                            to_acc;      // Result goes to accumulator

  // Field extraction from the instruction word
  assign is_ptr_in = (i_instr[asalu_pkg::OPC_HI:asalu_pkg::OPC_LO] == asalu_pkg::PTR_OPC); // [RQ11]
  assign req_in    = '{op: i_op, is_ptr: is_ptr_in, instr: i_instr, reg_data: i_reg_data};
  assign idle      = (state == asalu_pkg::ST_IDLE);
  assign cur       = idle ? req_in : held;
  assign take      = idle && i_valid;
  assign ptr_sel   = cur.instr[asalu_pkg::PTR_SEL_BIT];
  assign ptr_imm   = cur.instr[asalu_pkg::PTR_IMM_W-1:0];
  assign imm       = cur.instr[asalu_pkg::DATA_W-1:0];
  assign addr      = cur.instr[asalu_pkg::ADDR_W-1:0];
  assign dest      = cur.instr[asalu_pkg::DEST_BIT];

  // Register-operand operations and the indirect stretch
  assign reg_op = !cur.is_ptr &&
                  ((cur.op == asalu_pkg::OP_ADD_ACC_TO_REG) ||
                   (cur.op == asalu_pkg::OP_ADD_ACC_REG_WITH_CARRY) ||
                   (cur.op == asalu_pkg::OP_AND_ACC_WITH_REG) ||
                   (cur.op == asalu_pkg::OP_ARITH_SHIFT_RIGHT));
  assign ind_hit = reg_op &&
                   (((addr == INDIRECT_ADDR0) && ptr[0][asalu_pkg::PTR_MSB]) ||
                    ((addr == INDIRECT_ADDR1) && ptr[1][asalu_pkg::PTR_MSB])); // [RQ10]
  assign need_stretch = take && ind_hit;  // [RQ10]
  assign commit       = (take && !ind_hit) || !idle;
  assign o_ready      = idle;

  // Pointer arithmetic, natural 16-bit wrap
  assign ptr_ext = {{asalu_pkg::PTR_EXT_W{ptr_imm[asalu_pkg::PTR_IMM_W-1]}}, ptr_imm}; // [RQ1]
  assign ptr_sum = ptr[ptr_sel] + ptr_ext;  // [RQ2]

  // Adder shared by the three add operations
  assign is_add = !cur.is_ptr &&
                  ((cur.op == asalu_pkg::OP_ADD_IMM_TO_ACC) ||
                   (cur.op == asalu_pkg::OP_ADD_ACC_TO_REG) ||
                   (cur.op == asalu_pkg::OP_ADD_ACC_REG_WITH_CARRY));
  assign is_and = !cur.is_ptr &&
                  ((cur.op == asalu_pkg::OP_AND_ACC_WITH_REG) ||
                   (cur.op == asalu_pkg::OP_AND_ACC_WITH_IMM));
  assign is_asr = !cur.is_ptr && (cur.op == asalu_pkg::OP_ARITH_SHIFT_RIGHT);
  assign add_b  = (cur.op == asalu_pkg::OP_ADD_IMM_TO_ACC) ? imm : cur.reg_data; // [RQ3] [RQ4]
  assign cin    = (cur.op == asalu_pkg::OP_ADD_ACC_REG_WITH_CARRY) && flags.carry; // [RQ7]
  assign lo_sum = {1'b0, acc[asalu_pkg::NIB_W-1:0]} + {1'b0, add_b[asalu_pkg::NIB_W-1:0]}
                  + {4'h0, cin};  // [RQ12]
  assign full_sum = {1'b0, acc} + {1'b0, add_b} + {8'h00, cin};  // [RQ7]

  // Logic and shift units
  assign and_res = acc & ((cur.op == asalu_pkg::OP_AND_ACC_WITH_IMM) ? imm : cur.reg_data); // [RQ6] [RQ9]
  assign asr_res = {cur.reg_data[asalu_pkg::MSB], cur.reg_data[asalu_pkg::MSB:1]};  // [RQ8]

  // Result selection and destination
  assign result = is_add ? full_sum[asalu_pkg::DATA_W-1:0] :
                  is_and ? and_res :
                  is_asr ? asr_res : acc;
  assign to_acc = (cur.op == asalu_pkg::OP_ADD_IMM_TO_ACC) ||
                  (cur.op == asalu_pkg::OP_AND_ACC_WITH_IMM) || !dest;  // [RQ5]

  // Next accumulator and flags
  always_comb
  begin
    next_acc   = acc;
    next_flags = flags;
    if (commit && (is_add || is_and || is_asr))
    begin
      // Zero flag on every affecting operation
      next_flags.zero = (result == asalu_pkg::ZERO_B);  // [RQ12]
      if (to_acc)
      begin
        next_acc = result;  // [RQ5]
      end
      if (is_add)
      begin
        // Carry from bit 7, half carry from bit 3
        next_flags.carry      = full_sum[asalu_pkg::DATA_W];    // [RQ12]
        next_flags.half_carry = lo_sum[asalu_pkg::NIB_W];       // [RQ12]
      end
      else if (is_asr)
      begin
        next_flags.carry = cur.reg_data[0];  // [RQ8]
      end
    end
  end

  // Stretch sequencing
  always_comb
  begin
    case (state)
      asalu_pkg::ST_IDLE:
        next_state = need_stretch ? asalu_pkg::ST_STRETCH : asalu_pkg::ST_IDLE;  // [RQ10]
      asalu_pkg::ST_STRETCH:
        next_state = asalu_pkg::ST_IDLE;
      default:
        next_state = asalu_pkg::ST_IDLE;
    endcase
  end

  // State, accumulator and flags
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= asalu_pkg::ST_IDLE;
      acc   <= asalu_pkg::ACC_RST;
      flags <= '0;
      done  <= 1'b0;
    end
    else
    begin
      state <= next_state;
      acc   <= next_acc;
      flags <= next_flags;
      done  <= commit;
    end
  end

  // Hold the request over the extra cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      held <= '0;
    end
    else if (need_stretch)
    begin
      held <= req_in;
    end
  end

  // File register write-back port
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_mem_we    <= 1'b0;
      o_mem_addr  <= '0;
      o_mem_wdata <= asalu_pkg::ZERO_B;
    end
    else
    begin
      o_mem_we    <= commit && reg_op && dest;  // [RQ5]
      o_mem_addr  <= addr;
      o_mem_wdata <= result;
    end
  end

  // Pointer pairs, one per index
  for (genvar g = 0; g < asalu_pkg::NUM_PTR; g++)
  begin : g_ptr
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        ptr[g] <= asalu_pkg::PTR_RST;
      end
      else if (commit && cur.is_ptr && (ptr_sel == 1'(g)))
      begin
        ptr[g] <= ptr_sum;  // [RQ1] [RQ2] [RQ11]
      end
    end
  end

  // Output drive
  assign o_done       = done;
  assign o_acc        = acc;
  assign o_carry      = flags.carry;
  assign o_half_carry = flags.half_carry;
  assign o_zero       = flags.zero;
  assign o_ptr0       = ptr[0];
  assign o_ptr1       = ptr[1];

  // Pointer add leaves flags alone
  AST_PTR_FLAGS_KEEP: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ1]
    (commit && cur.is_ptr) |=> (flags == $past(flags)))
    else $error("pointer add changed a flag");

  // Pointer 0 gets its sign-extended literal with wrap
  AST_PTR_WRAP: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ2]
    (take && is_ptr_in && !i_instr[6]) |=>
      (o_ptr0 == 16'($past(o_ptr0) + {{10{$past(i_instr[5])}}, $past(i_instr[5:0])})))
    else $error("pointer sum wrong");

  // Literal add result and carry
  AST_ADD_IMM: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ3]
    (take && !is_ptr_in && (i_op == asalu_pkg::OP_ADD_IMM_TO_ACC)) |=>
      ({o_carry, o_acc} == {1'b0, $past(o_acc)} + {1'b0, $past(i_instr[7:0])}))
    else $error("literal add wrong");

  // Register add into accumulator
  AST_ADD_REG: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ4]
    (commit && reg_op && !dest && (cur.op == asalu_pkg::OP_ADD_ACC_TO_REG)) |=>
      ({o_carry, o_acc} == {1'b0, $past(o_acc)} + {1'b0, $past(cur.reg_data)}))
    else $error("register add wrong");

  // Destination one writes memory and keeps accumulator
  AST_DEST_REG: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ5]
    (commit && reg_op && dest) |=> (o_mem_we && (o_acc == $past(o_acc))
      && (o_mem_addr == $past(addr))))
    else $error("write-back to register wrong");

  // Register AND keeps carry and half carry
  AST_AND_REG: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ6]
    (commit && is_and && (cur.op == asalu_pkg::OP_AND_ACC_WITH_REG)) |=>
      ($stable(o_carry) && $stable(o_half_carry)))
    else $error("register AND touched carry");

  // Three-input sum
  AST_ADDC: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ7]
    (commit && !dest && (cur.op == asalu_pkg::OP_ADD_ACC_REG_WITH_CARRY) && !cur.is_ptr) |=>
      ({o_carry, o_acc} == {1'b0, $past(o_acc)} + {1'b0, $past(cur.reg_data)}
        + {8'h00, $past(o_carry)}))
    else $error("add with carry wrong");

  // Shift moves bit 0 to carry and keeps MSb
  AST_ASR: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ8]
    (commit && is_asr) |=> ((o_carry == $past(cur.reg_data[0]))
      && (o_mem_we || (o_acc[7] == $past(cur.reg_data[7])))))
    else $error("shift right wrong");

  // Literal AND result, carries kept
  AST_AND_IMM: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ9]
    (take && !is_ptr_in && (i_op == asalu_pkg::OP_AND_ACC_WITH_IMM)) |=>
      ((o_acc == ($past(o_acc) & $past(i_instr[7:0]))) && $stable(o_carry)
        && $stable(o_half_carry)))
    else $error("literal AND wrong");

  // Stretched request completes one cycle late
  AST_STRETCH: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ10]
    need_stretch |=> (!o_ready && !o_done) ##1 (o_ready && o_done))
    else $error("indirect stretch wrong");

  // Pointer add completes in one cycle
  AST_PTR_ONE: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ11]
    (take && is_ptr_in) |=> (o_done && o_ready))
    else $error("pointer add not single cycle");

  // Zero flag follows the result
  AST_ZERO: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ12]
    (commit && (is_add || is_and || is_asr)) |=> (o_zero == ($past(result) == 8'h00)))
    else $error("zero flag wrong");

endmodule // asalu_core

/* testbench/tb_add_and_shift_alu_ops.sv */
module tb_add_and_shift_alu_ops;
  timeunit 1ns;
  timeprecision 100ps;

  // Short operation names for the scenario tables
  localparam asalu_pkg::asalu_op_e NOP  = asalu_pkg::OP_NONE;
  localparam asalu_pkg::asalu_op_e ADDI = asalu_pkg::OP_ADD_IMM_TO_ACC;
  localparam asalu_pkg::asalu_op_e ADDR = asalu_pkg::OP_ADD_ACC_TO_REG;
  localparam asalu_pkg::asalu_op_e ADDC = asalu_pkg::OP_ADD_ACC_REG_WITH_CARRY;
  localparam asalu_pkg::asalu_op_e ANDR = asalu_pkg::OP_AND_ACC_WITH_REG;
  localparam asalu_pkg::asalu_op_e ANDI = asalu_pkg::OP_AND_ACC_WITH_IMM;
  localparam asalu_pkg::asalu_op_e ASR  = asalu_pkg::OP_ARITH_SHIFT_RIGHT;

  logic                  i_clk;        // Core clock
  logic                  i_rst;        // Sync reset
  logic                  i_valid;      // Request strobe
  logic [13:0]           i_instr;      // Instruction word
  asalu_pkg::asalu_op_e  i_op;         // Operation select
  logic [7:0]            i_reg_data;   // File register operand
  logic                  o_ready;      // Can accept
  logic                  o_done;       // Commit pulse
  logic [7:0]            o_acc;        // Accumulator
  logic                  o_carry;      // Carry flag
  logic                  o_half_carry; // Half-carry flag
  logic                  o_zero;       // Zero flag
  logic [15:0]           o_ptr0;       // Pointer pair 0
  logic [15:0]           o_ptr1;       // Pointer pair 1
  logic                  o_mem_we;     // Memory write pulse
  logic [6:0]            o_mem_addr;   // Memory address
  logic [7:0]            o_mem_wdata;  // Memory write data
  int                    err_count;    // Mismatches
  int                    comparisons;  // Compares made
  logic [7:0]            m_acc;        // Model accumulator
  logic                  m_c;          // Model carry
  logic                  m_hc;         // Model half-carry
  logic                  m_z;          // Model zero
  logic [15:0]           m_ptr [2];    // Model pointer pairs

  asalu_core u_asalu_core (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_valid      (i_valid),
    .i_instr      (i_instr),
    .i_op         (i_op),
    .i_reg_data   (i_reg_data),
    .o_ready      (o_ready),
    .o_done       (o_done),
    .o_acc        (o_acc),
    .o_carry      (o_carry),
    .o_half_carry (o_half_carry),
    .o_zero       (o_zero),
    .o_ptr0       (o_ptr0),
    .o_ptr1       (o_ptr1),
    .o_mem_we     (o_mem_we),
    .o_mem_addr   (o_mem_addr),
    .o_mem_wdata  (o_mem_wdata)
  );

  // 200 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One instruction: predict, drive, wait for commit, compare
  task automatic run(input asalu_pkg::asalu_op_e op, input logic [13:0] ins,
                     input logic [7:0] rd);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] res;
    logic       isptr;
    logic       regop;
    logic       wr;
    logic       str;
    logic       cin;
    isptr = (ins[13:7] == asalu_pkg::PTR_OPC);
    regop = !isptr && (op == ADDR || op == ADDC || op == ANDR || op == ASR);
    wr    = regop && ins[7];
    str   = regop && ((ins[6:0] == 7'h00 && m_ptr[0][15]) || (ins[6:0] == 7'h01 && m_ptr[1][15]));
    a     = m_acc;
    b     = (op == ADDI || op == ANDI) ? ins[7:0] : rd;
    cin   = (op == ADDC) ? m_c : 1'b0;
    s     = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h     = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    res   = 8'h00;
    if (isptr)
      m_ptr[ins[6]] = m_ptr[ins[6]] + {{10{ins[5]}}, ins[5:0]};
    else if (op == ADDI || op == ADDR || op == ADDC)
    begin
      res  = s[7:0];
      m_c  = s[8];
      m_hc = h[4];
    end
    else if (op == ANDI || op == ANDR)
      res = a & b;
    else if (op == ASR)
    begin
      res = {b[7], b[7:1]};
      m_c = b[0];
    end
    if (!isptr && op != NOP)
    begin
      m_z = (res == 8'h00);
      if (!wr)
        m_acc = res;
    end
    i_valid    = 1'b1;
    i_op       = op;
    i_instr    = ins;
    i_reg_data = rd;
    @(posedge i_clk);
    #1;
    // Strobe stays up: the next call or a reset replaces the request
    if (str)
    begin
      chk(o_ready, 1'b0);
      chk(o_done, 1'b0);
      @(posedge i_clk);
      #1;
    end
    chk(o_done, 1'b1);
    chk(o_acc, m_acc);
    chk({o_carry, o_half_carry, o_zero}, {m_c, m_hc, m_z});
    chk(o_ptr0, m_ptr[0]);
    chk(o_ptr1, m_ptr[1]);
    chk(o_mem_we, wr);
    if (wr)
      chk({o_mem_addr, o_mem_wdata}, {ins[6:0], res});
  endtask

  // Reset clears state, ready high afterwards
  task automatic t_reset();
    i_rst   = 1'b1;
    i_valid = 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    m_acc = 8'h00;
    {m_c, m_hc, m_z} = 3'b000;
    m_ptr = '{16'h0000, 16'h0000};
    chk({o_ready, o_done, o_mem_we}, 3'b100);
    chk({o_acc, o_carry, o_half_carry, o_zero}, 11'h000);
    chk(o_ptr0 | o_ptr1, 16'h0000);
  endtask

  // Literal add: nibble carry, byte carry to zero
  task automatic t_add_lit();
    run(ADDI, 14'h000F, 8'h00);
    run(ADDI, 14'h0001, 8'h00);
    run(ADDI, 14'h00F0, 8'h00);
  endtask

  // Pointer add with wrap both ways, flags held, op ignored
  task automatic t_ptr();
    run(ANDI, 14'h313F, 8'h00);
    run(NOP, 14'h3101, 8'h00);
    run(NOP, 14'h3120, 8'h00);
    run(NOP, 14'h315F, 8'h00);
  endtask

  // Register add to either destination
  task automatic t_add_reg();
    run(ADDI, 14'h0088, 8'h00);
    run(ADDR, 14'h0005, 8'h78);
    run(ADDR, 14'h00FF, 8'h01);
  endtask

  // Add with carry, carry in clear in all three, including carry out
  task automatic t_addc();
    run(ADDC, 14'h0010, 8'h00);
    run(ADDC, 14'h0010, 8'hFE);
    run(ADDI, 14'h0001, 8'h00);
    run(ADDC, 14'h00A0, 8'hFF);
  endtask

  // AND ops keep carry and half-carry
  task automatic t_and();
    run(ADDI, 14'h00C3, 8'h00);
    run(ANDI, 14'h0081, 8'h00);
    run(ANDR, 14'h0090, 8'h7E);
    run(ANDR, 14'h0010, 8'h7E);
  endtask

  // Shift keeps sign bit, bit 0 into carry
  task automatic t_asr();
    run(ASR, 14'h0020, 8'h81);
    run(ASR, 14'h00A0, 8'h01);
    run(ASR, 14'h0020, 8'h7E);
    run(NOP, 14'h0020, 8'h55);
  endtask

  // Indirect port with pointer top bit set adds a cycle
  task automatic t_stretch();
    run(ADDR, 14'h0000, 8'h11);
    run(ASR, 14'h0080, 8'h02);
    run(ADDR, 14'h0001, 8'h01);
    run(ADDI, 14'h0000, 8'h00);
    run(NOP, 14'h3160, 8'h00);
    run(ANDR, 14'h0081, 8'hFF);
  endtask

  // Main sequence
  initial
  begin
    err_count   = 0;
    comparisons = 0;
    i_instr     = 14'h0000;
    i_op        = NOP;
    i_reg_data  = 8'h00;
    t_reset();
    t_add_lit();
    t_ptr();
    t_add_reg();
    t_addc();
    t_and();
    t_asr();
    t_stretch();
    t_reset();
    t_add_lit();
    end_of_test();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (2000) @(posedge i_clk);
    err_count++;
    end_of_test();
  end
endmodule // tb_add_and_shift_alu_ops
